/* rtl/pfrs_pkg.sv */
/*
 * Shared constants and types for the pressure fault restart sequencer.
 * Assumes a single 125 MHz system clock; all settings arrive as plain ports.
 */
package pfrs_pkg;

	// time base
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned SECOND_NS = 1000000000;
	localparam int unsigned CYC_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
	localparam int unsigned SECS_PER_HOUR = 3600;

	// field widths
	localparam int TIME_W = 19;
	localparam int WAIT_W = 22;
	localparam int EXTRA_W = 20;
	localparam int CNT_W = 14;
	localparam int HOUR_W = 14;
	localparam int PRESS_W = 15;
	localparam int NUM_CAUSES = 3;

	// gain limits, integral and derivative in tenths
	localparam logic [3:0] KP_MAX = 4'ha;
	localparam logic [9:0] KI_MAX = 10'h3e8;
	localparam logic [9:0] KD_MAX = 10'h3e8;

	localparam logic [EXTRA_W-1:0] EXTRA_SAT = 20'hfffff;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_WAIT = 2'b11,
		ST_LOCK = 2'b10
	} pfrs_state_t;

	typedef enum logic [1:0] {
		CAUSE_OVER = 2'h0,
		CAUSE_UNDER = 2'h1,
		CAUSE_POWER = 2'h2
	} pfrs_cause_t;

endpackage

/* rtl/pfrs_sequencer.sv */
/*
 * Pressure fault restart sequencer: over-pressure trip, automatic restart
 * after over-pressure, under-pressure and power loss, restart counting,
 * lockout, and selection between ramp control and a PID loop.
 * Assumes all inputs synchronous to clock; under-pressure detection is
 * done upstream and arrives as a one-cycle trip pulse.
 */
`timescale 1ns/1ps

module pfrs_sequencer #(
	parameter int unsigned CYC_PER_SEC = pfrs_pkg::CYC_PER_SEC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// operator mode and commands
	input wire logic auto_mode,
	input wire logic run_cmd,
	input wire logic clear_counts,
	// plant side
	input wire logic power_ok,
	input wire logic [pfrs_pkg::PRESS_W-1:0] pressure,
	input wire logic under_trip,
	// over-pressure settings
	input wire logic [pfrs_pkg::PRESS_W-1:0] max_pressure,
	input wire logic over_shutdown_en,
	input wire logic [pfrs_pkg::TIME_W-1:0] over_ignore_s,
	input wire logic [pfrs_pkg::TIME_W-1:0] over_activation_s,
	input wire logic over_restart_en,
	input wire logic [pfrs_pkg::CNT_W-1:0] over_restart_max,
	input wire logic [pfrs_pkg::TIME_W-1:0] over_restart_delay_s,
	// under-pressure settings
	input wire logic under_restart_en,
	input wire logic [pfrs_pkg::CNT_W-1:0] under_restart_max,
	input wire logic under_type_pressure,
	input wire logic [pfrs_pkg::PRESS_W-1:0] under_recover_level,
	input wire logic [pfrs_pkg::TIME_W-1:0] under_restart_delay_s,
	input wire logic [pfrs_pkg::TIME_W-1:0] under_delay_incr_s,
	input wire logic pressure_ctrl_mode,
	// power-loss settings
	input wire logic power_restart_en,
	input wire logic [pfrs_pkg::CNT_W-1:0] power_restart_max,
	input wire logic [pfrs_pkg::TIME_W-1:0] power_restart_delay_s,
	input wire logic [pfrs_pkg::HOUR_W-1:0] clear_hours,
	// control method settings
	input wire logic pid_method,
	input wire logic speed_up_on_rise,
	input wire logic [pfrs_pkg::PRESS_W-1:0] target_pressure,
	input wire logic [3:0] pid_kp,
	input wire logic [9:0] pid_ki,
	input wire logic [9:0] pid_kd,
	// motor and status
	output logic motor_run,
	output logic restart_pending,
	output logic lockout,
	output logic [1:0] pending_cause,
	output logic [pfrs_pkg::CNT_W-1:0] over_count,
	output logic [pfrs_pkg::CNT_W-1:0] under_count,
	output logic [pfrs_pkg::CNT_W-1:0] power_count,
	// control method outputs
	output logic pid_enable,
	output logic ramp_enable,
	output logic [pfrs_pkg::PRESS_W-1:0] pid_setpoint,
	output logic [pfrs_pkg::PRESS_W-1:0] pid_process_var,
	output logic pid_speed_up,
	output logic [3:0] pid_kp_out,
	output logic [9:0] pid_ki_out,
	output logic [9:0] pid_kd_out
);

	pfrs_pkg::pfrs_state_t state_reg, state_next;
	pfrs_pkg::pfrs_cause_t cause_reg, cause_next, trip_cause;
	logic [31:0] tick_cnt_reg;
	logic tick;
	logic auto_q_reg;
	logic hand_to_auto;
	logic mode_change;
	logic [pfrs_pkg::TIME_W-1:0] run_secs_reg;
	logic [pfrs_pkg::TIME_W-1:0] over_secs_reg;
	logic [11:0] hour_secs_reg;
	logic [pfrs_pkg::HOUR_W-1:0] hours_reg;
	logic hours_clear;
	logic cnt_clear;
	logic [pfrs_pkg::WAIT_W-1:0] wait_reg;
	logic [pfrs_pkg::EXTRA_W-1:0] extra_reg;
	logic [pfrs_pkg::EXTRA_W:0] extra_sum;
	logic [pfrs_pkg::CNT_W-1:0] cnt_reg [pfrs_pkg::NUM_CAUSES];
	logic [pfrs_pkg::CNT_W-1:0] cnt_max [pfrs_pkg::NUM_CAUSES];
	logic over_cond;
	logic over_trip;
	logic trip;
	logic trip_en;
	logic load;
	logic [pfrs_pkg::WAIT_W-1:0] load_val;
	logic restart;
	logic ready;
	logic motor_run_reg;
	logic stop_hold_reg;

	localparam int WAIT_W = pfrs_pkg::WAIT_W;

	// one-second enable
	assign tick = (tick_cnt_reg == CYC_PER_SEC - 1);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			tick_cnt_reg <= 32'h0;
		else if (tick)
			tick_cnt_reg <= 32'h0;
		else
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			auto_q_reg <= 1'b0;
		else
			auto_q_reg <= auto_mode;
	end

	assign hand_to_auto = auto_mode & ~auto_q_reg;
	assign mode_change = auto_mode ^ auto_q_reg;

	// run time since start and continuous over-pressure time, in seconds
	assign over_cond = pressure > max_pressure;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			run_secs_reg <= '0;
			over_secs_reg <= '0;
		end
		else if (state_reg != pfrs_pkg::ST_RUN)
		begin
			run_secs_reg <= '0;
			over_secs_reg <= '0;
		end
		else
		begin
			if (tick && run_secs_reg != '1)
				run_secs_reg <= run_secs_reg + 1'b1;
			if (!over_cond)
				over_secs_reg <= '0;
			else if (tick && over_secs_reg != '1)
				over_secs_reg <= over_secs_reg + 1'b1;
		end
	end

	// gated, ignored at startup, then delayed
	assign over_trip = auto_mode && over_shutdown_en && over_cond &&
		(run_secs_reg >= over_ignore_s) && (over_secs_reg > over_activation_s);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			hour_secs_reg <= 12'h0;
			hours_reg <= '0;
		end
		else if (state_reg != pfrs_pkg::ST_RUN || hours_clear)
		begin
			hour_secs_reg <= 12'h0;
			hours_reg <= '0;
		end
		else if (tick)
		begin
			if (hour_secs_reg == 12'(pfrs_pkg::SECS_PER_HOUR - 1))
			begin
				hour_secs_reg <= 12'h0;
				hours_reg <= hours_reg + 1'b1;
			end
			else
				hour_secs_reg <= hour_secs_reg + 12'h1;
		end
	end

	assign hours_clear = (state_reg == pfrs_pkg::ST_RUN) && (clear_hours != '0) &&
		(hours_reg >= clear_hours);

	assign cnt_clear = hand_to_auto || clear_counts || hours_clear;

	assign cnt_max[pfrs_pkg::CAUSE_OVER] = over_restart_max;
	assign cnt_max[pfrs_pkg::CAUSE_UNDER] = under_restart_max;
	assign cnt_max[pfrs_pkg::CAUSE_POWER] = power_restart_max;

	// a restart in the clearing cycle still counts
	for (genvar i = 0; i < pfrs_pkg::NUM_CAUSES; i++)
	begin : g_cnt
		always_ff @(posedge clock or posedge rst)
		begin
			if (rst)
				cnt_reg[i] <= '0;
			else if (cnt_clear)
				cnt_reg[i] <= (restart && cause_reg == 2'(i)) ? 14'h1 : 14'h0;
			else if (restart && cause_reg == 2'(i) && cnt_reg[i] != '1)
				cnt_reg[i] <= cnt_reg[i] + 1'b1;
		end
	end

	always_comb
	begin
		ready = (wait_reg == '0);
		if (cause_reg == pfrs_pkg::CAUSE_UNDER && under_type_pressure)
			ready = pressure >= under_recover_level;
	end

	// trip source, priority power, over, under, operator stop
	always_comb
	begin
		trip = 1'b0;
		trip_en = 1'b0;
		trip_cause = pfrs_pkg::CAUSE_OVER;
		// power loss restarts only when enabled
		if (!power_ok)
		begin
			trip = 1'b1;
			trip_cause = pfrs_pkg::CAUSE_POWER;
			trip_en = power_restart_en;
		end
		else if (over_trip)
		begin
			trip = 1'b1;
			trip_cause = pfrs_pkg::CAUSE_OVER;
			trip_en = over_restart_en;
		end
		else if (under_trip)
		begin
			trip = 1'b1;
			trip_cause = pfrs_pkg::CAUSE_UNDER;
			trip_en = under_restart_en && pressure_ctrl_mode;
		end
	end

	always_comb
	begin
		state_next = state_reg;
		cause_next = cause_reg;
		load = 1'b0;
		load_val = '0;
		restart = 1'b0;
		case (state_reg)
			pfrs_pkg::ST_IDLE:
			begin
				if (run_cmd && power_ok && !stop_hold_reg)
					state_next = pfrs_pkg::ST_RUN;
			end
			pfrs_pkg::ST_RUN:
			begin
				if (trip)
				begin
					cause_next = trip_cause;
					if (!auto_mode || !trip_en)
						state_next = pfrs_pkg::ST_IDLE;
					else if (cnt_reg[trip_cause] >= cnt_max[trip_cause])
						state_next = pfrs_pkg::ST_LOCK;
					else
					begin
						state_next = pfrs_pkg::ST_WAIT;
						load = 1'b1;
					end
				end
				else if (!run_cmd)
					state_next = pfrs_pkg::ST_IDLE;
			end
			pfrs_pkg::ST_WAIT:
			begin
				if (!auto_mode)
					state_next = pfrs_pkg::ST_IDLE;
				else if (ready && power_ok)
				begin
					state_next = pfrs_pkg::ST_RUN;
					restart = 1'b1;
				end
			end
			pfrs_pkg::ST_LOCK:
			begin
				// held until mode change or clear
				if (mode_change || clear_counts)
					state_next = pfrs_pkg::ST_IDLE;
			end
			default:
				state_next = pfrs_pkg::ST_IDLE;
		endcase
		case (trip_cause)
			pfrs_pkg::CAUSE_OVER:
				load_val = WAIT_W'(over_restart_delay_s);
			pfrs_pkg::CAUSE_POWER:
				load_val = WAIT_W'(power_restart_delay_s);
			default:
				load_val = WAIT_W'(under_restart_delay_s) + WAIT_W'(extra_reg) +
					WAIT_W'(under_delay_incr_s);
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= pfrs_pkg::ST_IDLE;
			cause_reg <= pfrs_pkg::CAUSE_OVER;
			motor_run_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cause_reg <= cause_next;
			motor_run_reg <= (state_next == pfrs_pkg::ST_RUN);
		end
	end

	// unrestarted trip stays stopped
	// level run_cmd would otherwise restart at once
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			stop_hold_reg <= 1'b0;
		else if (state_reg == pfrs_pkg::ST_RUN && trip && (!auto_mode || !trip_en))
			stop_hold_reg <= 1'b1;
		else if (!run_cmd)
			stop_hold_reg <= 1'b0;
	end

	// restart wait timer, seconds
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			wait_reg <= '0;
		else if (load)
			wait_reg <= load_val;
		else if (state_reg != pfrs_pkg::ST_WAIT)
			wait_reg <= '0;
		else if (tick && wait_reg != '0)
			wait_reg <= wait_reg - 1'b1;
	end

	// accumulated increment, saturating to avoid wrap to short waits
	assign extra_sum = {1'b0, extra_reg} + (pfrs_pkg::EXTRA_W + 1)'(under_delay_incr_s);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			extra_reg <= '0;
		else if (cnt_clear)
			extra_reg <= '0;
		else if (restart && cause_reg == pfrs_pkg::CAUSE_UNDER && !under_type_pressure)
			extra_reg <= extra_sum[pfrs_pkg::EXTRA_W] ? pfrs_pkg::EXTRA_SAT :
				extra_sum[pfrs_pkg::EXTRA_W-1:0];
	end

	// control method routing and gain limits
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pid_enable <= 1'b0;
			ramp_enable <= 1'b1;
			pid_setpoint <= '0;
			pid_process_var <= '0;
			pid_speed_up <= 1'b1;
			pid_kp_out <= 4'h0;
			pid_ki_out <= 10'h0;
			pid_kd_out <= 10'h0;
		end
		else
		begin
			pid_enable <= pid_method;
			ramp_enable <= ~pid_method;
			pid_setpoint <= target_pressure;
			pid_process_var <= pressure;
			pid_speed_up <= speed_up_on_rise;
			pid_kp_out <= (pid_kp > pfrs_pkg::KP_MAX) ? pfrs_pkg::KP_MAX : pid_kp;
			pid_ki_out <= (pid_ki > pfrs_pkg::KI_MAX) ? pfrs_pkg::KI_MAX : pid_ki;
			pid_kd_out <= (pid_kd > pfrs_pkg::KD_MAX) ? pfrs_pkg::KD_MAX : pid_kd;
		end
	end

	assign motor_run = motor_run_reg;
	assign restart_pending = (state_reg == pfrs_pkg::ST_WAIT);
	assign lockout = (state_reg == pfrs_pkg::ST_LOCK);
	assign pending_cause = cause_reg;
	assign over_count = cnt_reg[pfrs_pkg::CAUSE_OVER];
	assign under_count = cnt_reg[pfrs_pkg::CAUSE_UNDER];
	assign power_count = cnt_reg[pfrs_pkg::CAUSE_POWER];

endmodule

/* sim/pfrs_monitor.sv */
/*
 * Concurrent checks on the sequencer's ports, bound into every instance.
 * Assumes one clock domain, rst asynchronous and active high.
 */
`timescale 1ns/1ps
module pfrs_monitor (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// watched inputs
	input wire logic auto_mode,
	input wire logic power_ok,
	// status
	input wire logic motor_run,
	input wire logic restart_pending,
	input wire logic lockout,
	input wire logic [pfrs_pkg::CNT_W-1:0] over_count,
	input wire logic [pfrs_pkg::CNT_W-1:0] under_count,
	input wire logic [pfrs_pkg::CNT_W-1:0] power_count,
	// control method
	input wire logic pid_enable,
	input wire logic ramp_enable,
	input wire logic [3:0] pid_kp_out
);
	default clocking mon_clk @(posedge clock);
	endclocking
	default disable iff (rst);

	AST_RAMP_XOR: assert property (ramp_enable != pid_enable)
		else $error("ramp and pid enables not exclusive");
	AST_KP_MAX: assert property (pid_kp_out <= pfrs_pkg::KP_MAX)
		else $error("proportional gain above limit");
	AST_WAIT_STOP: assert property (restart_pending |-> !motor_run)
		else $error("motor running while restart pending");
	AST_LOCK_STOP: assert property (lockout |-> !motor_run && !restart_pending)
		else $error("lockout not holding motor stopped");
	AST_HAND_CLEAR: assert property ($rose(auto_mode) |=>
		(over_count | under_count | power_count) == '0) else $error("counts kept");
	AST_AUTO_ONLY: assert property (!auto_mode |=> !restart_pending)
		else $error("restart pending outside auto");
	AST_PWR_HOLD: assert property (restart_pending && !power_ok |=> !motor_run)
		else $error("restart without power");
	AST_WAIT_SRC: assert property ($rose(restart_pending) |->
		$past(motor_run) && $past(auto_mode)) else $error("wait not entered from auto run");
endmodule

bind pfrs_sequencer pfrs_monitor mon (.*);

/* sim/pfrs_plant.sv */
/*
 * Far side: pressure sensor and the under-pressure detector feeding the
 * sequencer. Assumes the bench steers pressure through force_high/force_low.
 */
`timescale 1ns/1ps
module pfrs_plant #(
	// trip point below the recovery level
	parameter logic [14:0] MIN_TRIP = 15'h0100
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// steering
	input wire logic force_high,
	input wire logic force_low,
	// drive side
	input wire logic motor_run,
	output logic [14:0] pressure,
	output logic under_trip
);
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			pressure <= 15'h0400;
		else if (force_high)
			pressure <= 15'h2000;
		else if (force_low)
			pressure <= 15'h0010;
		else
			pressure <= 15'h0400;
	end

	// single pulse as a running pump first falls low
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			under_trip <= 1'b0;
		else
			under_trip <= motor_run && force_low && pressure >= MIN_TRIP;
	end
endmodule

/* sim/tb_top.sv */
/*
 * Bench for the sequencer: control-method table, then trip and restart runs.
 * Assumes pfrs_plant on the far side and a shortened second (CPS cycles).
 */
`timescale 1ns/1ps
module tb_top;
	localparam int CPS = 8;
	typedef struct packed {
		logic m;
		logic [3:0] kp;
		logic [9:0] ki, kd;
		logic [3:0] ekp;
		logic [9:0] eki, ekd;
	} pfrs_row_t;
	pfrs_row_t rows [4] = '{
		'{1'b1, 4'h3, 10'h005, 10'h020, 4'h3, 10'h005, 10'h020},
		'{1'b1, 4'hf, 10'h3ff, 10'h3e9, 4'ha, 10'h3e8, 10'h3e8},
		'{1'b0, 4'h0, 10'h000, 10'h000, 4'h0, 10'h000, 10'h000},
		'{1'b1, 4'ha, 10'h3e8, 10'h000, 4'ha, 10'h3e8, 10'h000}};
	logic clock = 1'b0, rst = 1'b1, auto_mode = 1'b1, run_cmd = 1'b1, clear_counts = 1'b0;
	logic power_ok = 1'b1, force_high = 1'b0, force_low = 1'b0, under_trip;
	logic over_shutdown_en = 1'b0, over_restart_en = 1'b1, under_restart_en = 1'b1;
	logic under_type_pressure = 1'b0, pressure_ctrl_mode = 1'b1, power_restart_en = 1'b1;
	logic pid_method = 1'b0, speed_up_on_rise = 1'b1;
	logic [14:0] pressure, max_pressure = 15'h1000, target_pressure = 15'h0456;
	// recovery above the plant trip point
	logic [14:0] under_recover_level = 15'h0200;
	// ignore longer than activation so the two can be told apart
	logic [18:0] over_ignore_s = 19'h4, over_activation_s = 19'h1, over_restart_delay_s = 19'h3;
	logic [18:0] under_restart_delay_s = 19'h2, under_delay_incr_s = 19'h2;
	logic [18:0] power_restart_delay_s = 19'h2;
	logic [13:0] over_restart_max = 14'h1, under_restart_max = 14'h2;
	logic [13:0] power_restart_max = 14'h1, clear_hours = 14'h0;
	logic [3:0] pid_kp = 4'h1, pid_kp_out;
	logic [9:0] pid_ki = 10'h1, pid_kd = 10'h0, pid_ki_out, pid_kd_out;
	logic motor_run, restart_pending, lockout, pid_enable, ramp_enable, pid_speed_up;
	logic [1:0] pending_cause;
	logic [13:0] over_count, under_count, power_count;
	logic [14:0] pid_setpoint, pid_process_var;
	int mismatches = 0, comparisons = 0, n;

	pfrs_sequencer #(.CYC_PER_SEC(CPS)) uut (.*);
	pfrs_plant plant (.*);

	initial forever #4 clock = ~clock;

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask

	// hang guard: a wait that runs out ends the run
	task automatic wait_run(input logic v, input int lim);
		n = 0;
		// look only after the edge's updates have settled
		#1;
		while (motor_run !== v && n < lim)
		begin
			cyc(1);
			n++;
		end
		if (motor_run !== v)
		begin
			mismatches++;
			complete_run();
		end
	endtask

	task automatic dip(input logic hold);
		@(posedge clock);
		force_low <= 1'b1;
		if (!hold)
		begin
			@(posedge clock);
			force_low <= 1'b0;
		end
		wait_run(0, 8);
	endtask

	initial
	begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		cyc(1);
		chk({lockout, restart_pending, ramp_enable, over_count}, 17'h04000);
		wait_run(1, 4);
		foreach (rows[i])
		begin
			@(posedge clock);
			pid_method <= rows[i].m;
			pid_kp <= rows[i].kp;
			pid_ki <= rows[i].ki;
			pid_kd <= rows[i].kd;
			speed_up_on_rise <= rows[i].kp[0];
			target_pressure <= {5'h00, rows[i].ki};
			cyc(3);
			chk({pid_enable, ramp_enable}, {rows[i].m, !rows[i].m});
			chk({pid_kp_out, pid_ki_out, pid_kd_out}, {rows[i].ekp, rows[i].eki, rows[i].ekd});
			if (rows[i].m)
				chk({pid_setpoint, pid_process_var, pid_speed_up}, {target_pressure, pressure, rows[i].kp[0]});
		end
		dip(1'b0);
		wait_run(1, 6 * CPS);
		chk(n >= 3 * CPS && n <= 4 * CPS + 3, 1);
		chk(under_count, 14'h1);
		dip(1'b0);
		wait_run(1, 8 * CPS);
		chk(n >= 5 * CPS && n <= 6 * CPS + 3, 1);
		dip(1'b0);
		cyc(2);
		chk({lockout, under_count}, {1'b1, 14'h2});
		@(posedge clock);
		clear_counts <= 1'b1;
		@(posedge clock);
		clear_counts <= 1'b0;
		under_type_pressure <= 1'b1;
		wait_run(1, 8);
		chk({lockout, under_count}, 15'h0);
		dip(1'b1);
		cyc(3 * CPS);
		chk({restart_pending, motor_run}, 2'h2);
		@(posedge clock);
		force_low <= 1'b0;
		clear_hours <= 14'h1;
		wait_run(1, 4);
		chk(under_count, 14'h1);
		cyc(3602 * CPS);
		chk(under_count, 14'h0);
		@(posedge clock);
		clear_hours <= 14'h0;
		force_high <= 1'b1;
		cyc(6 * CPS);
		chk(motor_run, 1);
		// let the over timer restart from zero before enabling
		@(posedge clock);
		force_high <= 1'b0;
		cyc(2);
		@(posedge clock);
		over_shutdown_en <= 1'b1;
		force_high <= 1'b1;
		cyc(CPS + 1);
		chk(motor_run, 1);
		wait_run(0, 2 * CPS);
		cyc(1);
		chk({restart_pending, pending_cause}, 3'h4);
		wait_run(1, 4 * CPS + 4);
		chk(n > 2 * CPS, 1);
		cyc(3 * CPS);
		chk(motor_run, 1);
		wait_run(0, 3 * CPS);
		cyc(2);
		chk({lockout, over_count}, {1'b1, 14'h1});
		@(posedge clock);
		force_high <= 1'b0;
		auto_mode <= 1'b0;
		cyc(2);
		chk(over_count, 14'h1);
		@(posedge clock);
		auto_mode <= 1'b1;
		cyc(2);
		chk({lockout, over_count}, 15'h0);
		wait_run(1, 8);
		@(posedge clock);
		power_ok <= 1'b0;
		wait_run(0, 4);
		cyc(1);
		chk({restart_pending, pending_cause}, 3'h6);
		// power back early: the delay alone must hold the motor off
		@(posedge clock);
		power_ok <= 1'b1;
		wait_run(1, 3 * CPS);
		chk(n >= CPS, 1);
		chk(power_count, 14'h1);
		@(posedge clock);
		power_ok <= 1'b0;
		wait_run(0, 4);
		cyc(2);
		chk(lockout, 1);
		@(posedge clock);
		auto_mode <= 1'b0;
		cyc(1);
		@(posedge clock);
		auto_mode <= 1'b1;
		power_ok <= 1'b1;
		wait_run(1, 4);
		chk({lockout, power_count}, 15'h0);
		@(posedge clock);
		power_ok <= 1'b0;
		wait_run(0, 4);
		@(posedge clock);
		auto_mode <= 1'b0;
		cyc(2);
		chk(restart_pending, 0);
		@(posedge clock);
		auto_mode <= 1'b1;
		power_restart_en <= 1'b0;
		power_ok <= 1'b1;
		wait_run(1, 4);
		@(posedge clock);
		power_ok <= 1'b0;
		cyc(4);
		chk({restart_pending, motor_run}, 2'h0);
		@(posedge clock);
		power_ok <= 1'b1;
		cyc(4);
		chk(motor_run, 0);
		complete_run();
	end
endmodule
